// ---- rtl/direct_power_mode_transition.v ----
// Purpose: direct transitions medium-speed to subactive and subactive to high-speed
// Assumes: osc_tick marks one oscillator state, sub_tick one subclock state,
//   cpu states follow osc_tick in active modes and sub_tick in subactive; logic on clk
// Notes: one clock of watch on the way down to subactive; one transition at a time
// Notes on behaviour
// - medium-speed, sleep with standby, low, watch and direct set: via watch into subactive
// - subactive, sleep with standby, watch set, low and medium clear, direct set
// - stay in watch for the selected oscillator wait before resuming high-speed
// - total time is sleep plus internal, then wait, then exception states
// - sleep is 2 states, internal 1, exception handling 14
// - pre-transition clock counts sleep and internal, post clock counts exception
// - transition completes only when exception handling is finished
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_regs.vh"
module direct_power_mode_transition (
  input wire clk,
  input wire rst,
  input wire osc_tick,
  input wire sub_tick,
  input wire sleep_exec,
  input wire standby_select,
  input wire low_speed_on,
  input wire watch_mode_select,
  input wire direct_transition_on,
  input wire medium_speed_on,
  input wire [2:0] standby_wait_select,
  output reg [1:0] mode,
  output reg in_transition,
  output reg exception_active,
  output reg transition_done
);
// ==========================================
// sequencer states
localparam ST_IDLE = 3'h0;
localparam ST_SLEEP = 3'h1;
localparam ST_WAIT = 3'h2;
localparam ST_EXC = 3'h3;

// ==========================================
// registers
reg [2:0] state;
reg [4:0] state_count;
reg [13:0] wait_count;
reg [1:0] target;
reg [1:0] source;

// ==========================================
// next values, all settled by one combinational process
reg [2:0] next_state;
reg [4:0] next_state_count;
reg [13:0] next_wait_count;
reg [1:0] next_target;
reg [1:0] next_source;
reg [1:0] next_mode;
reg next_in_transition;
reg next_exception_active;
reg next_transition_done;

// ==========================================
// decode and tick selection
reg [13:0] wait_len;
wire to_sub;
wire to_high;
wire pre_tick;
wire post_tick;

// ==========================================
// transition request decode
// assumed: bits are stable when sleep_exec pulses
assign to_sub = (mode == `MODE_MEDIUM) && standby_select && low_speed_on &&
  watch_mode_select && direct_transition_on;
assign to_high = (mode == `MODE_SUB) && standby_select && watch_mode_select &&
  !low_speed_on && !medium_speed_on && direct_transition_on;
// medium-speed cpu states are osc states; subactive cpu states are sub states
assign pre_tick = (source == `MODE_SUB) ? sub_tick : osc_tick;
assign post_tick = (target == `MODE_SUB) ? sub_tick : osc_tick;

// ==========================================
// oscillator wait table, code 0 is the longest wait
always @*
begin
  case (standby_wait_select)
    3'h0: wait_len = `WAIT_0;
    3'h1: wait_len = `WAIT_1;
    3'h2: wait_len = `WAIT_2;
    3'h3: wait_len = `WAIT_3;
    3'h4: wait_len = `WAIT_4;
    3'h5: wait_len = `WAIT_5;
    3'h6: wait_len = `WAIT_6;
    default: wait_len = `WAIT_7;
  endcase
end
// ==========================================
// next-state logic; counters only move on their own mode's tick
always @*
begin
  // defaults hold every register; done is a one-clock pulse
  next_state = state;
  next_state_count = state_count;
  next_wait_count = wait_count;
  next_target = target;
  next_source = source;
  next_mode = mode;
  next_in_transition = in_transition;
  next_exception_active = exception_active;
  next_transition_done = 1'b0;

  case (state)
    ST_IDLE:
    begin
      // refused requests leave every output as it stands
      if (sleep_exec && (to_sub || to_high))
      begin
        next_source = mode;
        next_target = to_sub ? `MODE_SUB : `MODE_HIGH;
        next_wait_count = wait_len;
        next_state_count = `SLEEP_STATES + `INTERNAL_STATES;
        next_in_transition = 1'b1;
        next_state = ST_SLEEP;
      end
    end

    ST_SLEEP:
    begin
      // sleep and internal states run on the clock of the mode being left
      if (pre_tick)
      begin
        if (state_count == 5'h01)
        begin
          next_mode = `MODE_WATCH;
          next_state = ST_WAIT;
        end
        else
          next_state_count = state_count - 5'h01;
      end
    end

    ST_WAIT:
    begin
      if (target == `MODE_SUB)
      begin
        // no oscillator wait going down: watch lasts a single clock
        next_mode = `MODE_SUB;
        next_state_count = `EXCEPTION_STATES;
        next_exception_active = 1'b1;
        next_state = ST_EXC;
      end
      else if (osc_tick)
      begin
        if (wait_count == 14'h0001)
        begin
          next_mode = `MODE_HIGH;
          next_state_count = `EXCEPTION_STATES;
          next_exception_active = 1'b1;
          next_state = ST_EXC;
        end
        else
          next_wait_count = wait_count - 14'h0001;
      end
    end

    ST_EXC:
    begin
      // handling states count on the clock of the mode just entered
      if (post_tick)
      begin
        if (state_count == 5'h01)
        begin
          next_exception_active = 1'b0;
          next_in_transition = 1'b0;
          next_transition_done = 1'b1;
          next_state = ST_IDLE;
        end
        else
          next_state_count = state_count - 5'h01;
      end
    end

    default:
      next_state = ST_IDLE;
  endcase
end

// ==========================================
// sequencer registers
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    state <= ST_IDLE;
    state_count <= 5'h00;
    wait_count <= 14'h0000;
    target <= `MODE_HIGH;
    source <= `MODE_HIGH;
  end
  else
  begin
    state <= next_state;
    state_count <= next_state_count;
    wait_count <= next_wait_count;
    target <= next_target;
    source <= next_source;
  end
end

// ==========================================
// outputs, each straight from a flip-flop; reset leaves medium-speed mode
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    mode <= `MODE_MEDIUM;
    in_transition <= 1'b0;
    exception_active <= 1'b0;
    transition_done <= 1'b0;
  end
  else
  begin
    mode <= next_mode;
    in_transition <= next_in_transition;
    exception_active <= next_exception_active;
    transition_done <= next_transition_done;
  end
end

endmodule
`default_nettype wire

// ---- rtl/power_mode_regs.vh ----
// Purpose: constants for the direct power-mode transition controller
// Assumes: one 125 MHz system clock; mode clocks are modelled as enable ticks
// Notes: state counts are in CPU or subclock states
`ifndef POWER_MODE_REGS_VH
`define POWER_MODE_REGS_VH
// ==========================================
// state counts
`define SLEEP_STATES 5'h02
`define INTERNAL_STATES 5'h01
`define EXCEPTION_STATES 5'h0e
// ==========================================
// operating modes
`define MODE_HIGH 2'h0
`define MODE_MEDIUM 2'h1
`define MODE_SUB 2'h2
`define MODE_WATCH 2'h3
// ==========================================
// wait table, oscillator states per standby_wait_select code
`define WAIT_0 14'h2000
`define WAIT_1 14'h1000
`define WAIT_2 14'h0800
`define WAIT_3 14'h0400
`define WAIT_4 14'h0200
`define WAIT_5 14'h0100
`define WAIT_6 14'h0080
`define WAIT_7 14'h0040
`endif

// ---- verif/cpu_core_model.sv ----
// Purpose: cpu side, turns a go request into one sleep pulse
// Assumes: control bits already set by the bench
// Notes: pulse is one cycle
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input wire clk,
  input wire go,
  output logic sleep_exec
);
  // one cycle late so the bits are settled first
  always @(posedge clk) sleep_exec <= go;
endmodule
`default_nettype wire

// ---- verif/direct_power_mode_transition_checker.sv ----
// Purpose: port checks
// Assumes: clk domain only
// Notes: none
`timescale 1ns/1ps
`default_nettype none
module power_mode_checker (
  input wire clk,
  input wire rst,
  input wire sleep_exec,
  input wire standby_select,
  input wire low_speed_on,
  input wire watch_mode_select,
  input wire direct_transition_on,
  input wire medium_speed_on,
  input wire [1:0] mode,
  input wire in_transition,
  input wire exception_active,
  input wire transition_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire arm = sleep_exec && !in_transition && standby_select && watch_mode_select;
  property p_med;
    arm && mode == 2'h1 && low_speed_on && direct_transition_on |=> in_transition;
  endproperty
  a_med: assert property (p_med) else $error("medium sleep not taken");
  property p_sub;
    arm && mode == 2'h2 && !low_speed_on && !medium_speed_on && direct_transition_on
      |=> in_transition;
  endproperty
  a_sub: assert property (p_sub) else $error("subactive sleep not taken");
  property p_high;
    $rose(exception_active) && mode == 2'h0 |-> $past(mode) == 2'h3;
  endproperty
  a_high: assert property (p_high) else $error("high without watch");
  property p_end;
    transition_done |-> $past(exception_active) && !exception_active;
  endproperty
  a_end: assert property (p_end) else $error("done before handling");
  property p_post;
    $rose(exception_active) |-> mode == 2'h2 || mode == 2'h0;
  endproperty
  a_post: assert property (p_post) else $error("handling in wrong mode");
  property p_watch;
    $rose(exception_active) && mode == 2'h2 |-> $past(mode) == 2'h3;
  endproperty
  a_watch: assert property (p_watch) else $error("subactive without watch");
  property p_refuse;
    sleep_exec && !in_transition && !(standby_select && watch_mode_select &&
      direct_transition_on && ((mode == 2'h1 && low_speed_on) ||
      (mode == 2'h2 && !low_speed_on && !medium_speed_on))) |=> !in_transition;
  endproperty
  a_refuse: assert property (p_refuse) else $error("sleep taken with wrong bits");
endmodule
bind direct_power_mode_transition power_mode_checker chk (.*);
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: directed transitions
// Assumes: osc tick every cycle, sub tick every second
// Notes: wait code 7, then code 0 after a second reset
`timescale 1ns/1ps
`default_nettype none
module testbench;
  reg clk = 0, rst = 1, go = 0, sub = 0, ss = 0, ls = 0, wm = 0, dt = 0, ms = 0;
  reg [2:0] ws = 3'h7;
  wire sl, it, ea, td;
  wire [1:0] mode;
  integer errors = 0, n_tests = 0, c, w, e;
  cpu_core_model cpu (.clk(clk), .go(go), .sleep_exec(sl));
  direct_power_mode_transition dut (.clk(clk), .rst(rst), .osc_tick(1'b1),
    .sub_tick(sub), .sleep_exec(sl), .standby_select(ss), .low_speed_on(ls),
    .watch_mode_select(wm), .direct_transition_on(dt), .medium_speed_on(ms),
    .standby_wait_select(ws), .mode(mode), .in_transition(it),
    .exception_active(ea), .transition_done(td));
  initial forever #4 clk = ~clk;
  always @(posedge clk) sub <= ~sub;
  task chk(input string n, input [15:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  // counts clocks to done, clocks in watch and clocks of exception handling
  task run(input [4:0] b, input [2:0] k, input integer lim);
    @(posedge clk) {ss, ls, wm, dt, ms} <= b;
    ws <= k;
    @(posedge clk) go <= 1;
    @(posedge clk) go <= 0;
    c = 0;
    w = 0;
    e = 0;
    while (td !== 1'b1 && c < lim)
    begin
      @(posedge clk);
      #1 c++;
      if (mode === 2'h3) w++;
      if (ea === 1'b1) e++;
    end
  endtask
  task close_out;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 0;
    run(5'b11110, 3'h7, 300);
    chk("done", td, 16'h1);
    chk("mode", mode, 16'h2);
    chk("watch", w, 16'h1);
    chk("time", c >= 31 && c <= 34, 16'h1);
    chk("exc", e >= 27 && e <= 28, 16'h1);
    run(5'b11111, 3'h7, 50);
    chk("busy", it, 16'h0);
    chk("done", td, 16'h0);
    chk("mode", mode, 16'h2);
    run(5'b10110, 3'h7, 300);
    chk("done", td, 16'h1);
    chk("mode", mode, 16'h0);
    chk("wait", w, 16'h40);
    chk("exc", e, 16'he);
    chk("time", c >= 84 && c <= 86, 16'h1);
    @(posedge clk) rst <= 1;
    repeat (3) @(posedge clk);
    rst <= 0;
    chk("reset mode", mode, 16'h1);
    chk("reset busy", it, 16'h0);
    run(5'b11110, 3'h0, 300);
    chk("done", td, 16'h1);
    chk("mode", mode, 16'h2);
    run(5'b10110, 3'h0, 9000);
    chk("done", td, 16'h1);
    chk("mode", mode, 16'h0);
    chk("wait", w, 16'h2000);
    chk("exc", e, 16'he);
    chk("time", c >= 8212 && c <= 8214, 16'h1);
    close_out();
  end
  // longest case is the 8192-state wait, about 8450 clocks in all
  initial
  begin
    #100000 errors++;
    close_out();
  end
endmodule
`default_nettype wire
